// ==== hw/fic_pkg.sv ====
// package: opcodes, register bit positions, timing counts for the command block
package fic_pkg;
  // instruction codes
  localparam logic [7:0] OP_QUAD_ID   = 8'haf;
  localparam logic [7:0] OP_ID        = 8'h9f;
  localparam logic [7:0] OP_PARAM     = 8'h5a;
  localparam logic [7:0] OP_STAT1     = 8'h05;
  localparam logic [7:0] OP_STAT2     = 8'h07;
  localparam logic [7:0] OP_CFG       = 8'h35;
  localparam logic [7:0] OP_REG_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD      = 8'h06;
  // first status register fields
  localparam int SR1_WIP   = 0;
  localparam int SR1_WEL   = 1;
  localparam int SR1_BP_LO = 2;
  localparam int SR1_BP_HI = 4;
  localparam int SR1_EFAIL = 5;
  localparam int SR1_PFAIL = 6;
  localparam int SR1_STATUS_WRITE_DISABLE  = 7;
  // configuration register fields
  localparam int CR1_QUAD      = 1;
  localparam int CR1_BP_NV_SEL = 3;
  localparam int CR2_QUAD_ALL  = 6;
  // address and dummy lengths
  localparam int ADDR_BITS   = 24;
  localparam int DUMMY_CYCLES = 8;
  // reset values
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] CR1_RESET = 8'h00;
  // self-timed register write duration
  localparam int WRITE_TIME_NS = 2000;
  localparam int CLOCK_NS      = 10;
  localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLOCK_NS;
endpackage

// ==== hw/fic_sync.sv ====
// two-stage synchroniser for a level
`timescale 1ns/1ns
`default_nettype none
module fic_sync
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // level in and out
  input  wire logic level_i,
  output logic      level_o
);
  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      meta_q  <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      meta_q  <= level_i;
      level_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== hw/fic_cmd.sv ====
// serial flash command interpreter: id, parameter, register read and write
// Summary of operation
// - quad id read decoded only in quad-all mode
// - id order: maker, two device, extended, structure
// - chip select high ends output; overrun wraps
// - parameter bytes shift out msb first
// - address selects start in parameter space
// - quad-all reads: four lines, two clocks/byte
// - status one readable any time, even busy
// - status one repeats, refreshed every byte
// - status two readable outside quad-all, repeating
// - configuration readable any time, repeating
// - register write needs write enable latch set
// - eight bits: status only; sixteen: both
// - start at select rise; busy then clear latch
// - failed write sets program and erase flags
// - select bit routes protect field nv or volatile
// - status write disable with protect pin locks
// - quad-all register write on four lines
// - write enable sets latch unless busy, status bit one
// - write in progress is status bit zero
// - disabled and pin low: silent rejection
// - quad mode disables hardware protection
`timescale 1ns/1ns
`default_nettype none
module fic_cmd
#(
  parameter int ID_DEPTH    = 64,
  parameter int PARAM_DEPTH = 256,
  parameter int WRITE_CYCLES = fic_pkg::WRITE_CYCLES
)
(
  // system clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // link pins: serial clock and chip select
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  // four data lines, each split in three
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o,
  // write protect pin (shared with io 2 in quad mode)
  input  wire logic        wp_n_i,
  // configuration bits from elsewhere in the device
  input  wire logic [7:0]  second_config_volatile_i,
  input  wire logic        protect_field_nonvolatile_select_i,
  input  wire logic [7:0]  status_two_i,
  // failure injection from the register array
  input  wire logic        write_fail_i,
  // register state shown outward
  output logic      [7:0]  first_status_volatile_o,
  output logic      [7:0]  first_status_nonvolatile_o,
  output logic      [7:0]  first_config_volatile_o,
  // table loading ports for identification and parameter bytes
  input  wire logic        table_we_i,
  input  wire logic        table_sel_i,
  input  wire logic [7:0]  table_addr_i,
  input  wire logic [7:0]  table_data_i
);
  typedef enum logic [4:0]
  {
    ST_OPCODE = 5'h01,
    ST_ADDR   = 5'h02,
    ST_DUMMY  = 5'h04,
    ST_READ   = 5'h08,
    ST_WDATA  = 5'h10
  } fic_state_t;

  typedef enum logic [2:0]
  {
    SRC_ID   = 3'h0,
    SRC_PAR  = 3'h1,
    SRC_SR1  = 3'h2,
    SRC_SR2  = 3'h3,
    SRC_CR1  = 3'h4
  } fic_src_t;

  // tables held in the device
  logic [7:0] id_mem    [ID_DEPTH];
  logic [7:0] param_mem [PARAM_DEPTH];

  // link-domain state
  fic_state_t  state_q;
  fic_src_t    src_q;
  logic [4:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [23:0] ptr_q;
  logic [15:0] wdata_q;
  logic [4:0]  wbits_q;
  logic        wr_cmd_q;
  logic        write_enable_cmd_seen_q;
  logic [4:0]  addr_cnt_q;
  logic [3:0]  dummy_q;
  logic [7:0]  out_q;
  logic [2:0]  out_cnt_q;
  logic        drive_q;
  logic        req_tog_q;
  logic        write_enable_cmd_tog_q;
  logic [15:0] req_data_q;
  logic        req_two_q;

  // system-domain register state
  logic [7:0]  first_status_volatile_q;
  logic [7:0]  first_status_nonvolatile_q;
  logic [7:0]  first_config_volatile_q;
  logic [$clog2(WRITE_CYCLES+1)-1:0] busy_cnt_q;
  logic        req_seen_q;
  logic        write_enable_cmd_seen_sys_q;

  // crossing values: synchronised into the system clock, direct into the link
  logic        req_sync;
  logic        write_enable_cmd_sync;
  logic        quad_all;
  logic [7:0]  sr1_link;
  logic [7:0]  cr1_link;
  logic        wp_sync;

  // quad-all bit from second configuration register
  assign quad_all = second_config_volatile_i[fic_pkg::CR2_QUAD_ALL];

  // register snapshots are quasi-static bytes read only at byte boundaries
  // in the link domain; a torn read shows an old or new bit, never a glitch
  assign sr1_link = first_status_volatile_q;
  assign cr1_link = first_config_volatile_q;

  // incoming bits: one line in single mode, four in quad-all
  wire        lanes4    = quad_all;
  wire [7:0]  shifted   = lanes4 ? {shift_q[3:0], io_i}
                                 : {shift_q[6:0], io_i[0]};
  wire [4:0]  step      = lanes4 ? 5'd4 : 5'd1;
  wire [4:0]  bits_next = bit_cnt_q + step;
  wire        byte_done = bits_next[3];
  wire [7:0]  opcode    = shifted;

  // opcode decode
  wire op_qid  = (opcode == fic_pkg::OP_QUAD_ID) && quad_all;
  wire op_id   = (opcode == fic_pkg::OP_ID);
  wire op_par  = (opcode == fic_pkg::OP_PARAM);
  wire op_sr1  = (opcode == fic_pkg::OP_STAT1);
  wire op_sr2  = (opcode == fic_pkg::OP_STAT2) && !quad_all;
  wire op_cr1  = (opcode == fic_pkg::OP_CFG);
  wire op_wrr  = (opcode == fic_pkg::OP_REG_WRITE);
  wire op_write_enable_cmd = (opcode == fic_pkg::OP_WRITE_ENABLE_CMD);
  // last address bit arrives on this edge
  wire addr_done = (addr_cnt_q + step) == 5'(fic_pkg::ADDR_BITS);

  // byte to send next from the chosen source
  wire [7:0] id_byte  = id_mem[ptr_q[$clog2(ID_DEPTH)-1:0]];
  wire [7:0] par_byte = param_mem[ptr_q[$clog2(PARAM_DEPTH)-1:0]];
  wire [7:0] next_byte =
    (src_q == SRC_ID)  ? id_byte  :
    (src_q == SRC_PAR) ? par_byte :
    (src_q == SRC_SR1) ? sr1_link :
    (src_q == SRC_SR2) ? status_two_i :
    cr1_link;

  // table load from the system side
  always_ff @(posedge clock_i)
  begin
    if (table_we_i && !table_sel_i)
      id_mem[table_addr_i[$clog2(ID_DEPTH)-1:0]] <= table_data_i;
    if (table_we_i && table_sel_i)
      param_mem[table_addr_i] <= table_data_i;
  end

  // input side of the link: commands sampled on rising sck
  always_ff @(posedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      state_q   <= ST_OPCODE;
      bit_cnt_q <= 5'd0;
      shift_q   <= 8'h00;
    end
    else
    begin
      shift_q   <= shifted;
      bit_cnt_q <= byte_done ? 5'd0 : bits_next;
      case (state_q)
        ST_OPCODE:
          if (byte_done)
          begin
            if (op_par)
              state_q <= ST_ADDR;
            else if (op_qid || op_id || op_sr1 || op_sr2 || op_cr1)
              state_q <= ST_READ;
            else if (op_wrr)
              state_q <= ST_WDATA;
            else
              state_q <= ST_OPCODE;
          end
        ST_ADDR:
          if (addr_done)
            state_q <= ST_DUMMY;
        ST_DUMMY:
          if (dummy_q == 4'(fic_pkg::DUMMY_CYCLES - 1))
            state_q <= ST_READ;
        default:
          state_q <= state_q;
      endcase
    end
  end

  // address, source, write data and dummy tracking
  always_ff @(posedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      addr_cnt_q  <= 5'd0;
      dummy_q     <= 4'd0;
      src_q       <= SRC_ID;
      wdata_q     <= 16'h0000;
      wbits_q     <= 5'd0;
      wr_cmd_q    <= 1'b0;
      write_enable_cmd_seen_q <= 1'b0;
    end
    else
    begin
      if (state_q == ST_OPCODE && byte_done)
      begin
        src_q <= op_par ? SRC_PAR : op_sr1 ? SRC_SR1 :
                 op_sr2 ? SRC_SR2 : op_cr1 ? SRC_CR1 : SRC_ID;
        wr_cmd_q    <= op_wrr;
        write_enable_cmd_seen_q <= op_write_enable_cmd;
      end
      else
        write_enable_cmd_seen_q <= 1'b0;  // more clocks after opcode cancel it
      if (state_q == ST_ADDR)
        addr_cnt_q <= addr_cnt_q + step;
      if (state_q == ST_DUMMY)
        dummy_q <= dummy_q + 4'd1;
      if (state_q == ST_WDATA && wbits_q < 5'd16)
      begin
        wdata_q <= lanes4 ? {wdata_q[11:0], io_i}
                          : {wdata_q[14:0], io_i[0]};
        wbits_q <= wbits_q + step;
      end
    end
  end

  // pointer: loaded from address, then stepped per byte out
  wire read_phase = (state_q == ST_READ);
  wire [23:0] addr_shift = lanes4 ? {ptr_q[19:0], io_i}
                                  : {ptr_q[22:0], io_i[0]};
  logic load_q;

  // output side: data driven on falling sck, msb first
  always_ff @(negedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      out_q     <= 8'h00;
      out_cnt_q <= 3'd0;
      drive_q   <= 1'b0;
      load_q    <= 1'b1;
    end
    else if (read_phase)
    begin
      drive_q <= 1'b1;
      if (load_q || out_cnt_q == 3'd0)
      begin
        out_q     <= next_byte;  // top bits go out first
        out_cnt_q <= lanes4 ? 3'd1 : 3'd7;
        load_q    <= 1'b0;
      end
      else
      begin
        out_q     <= lanes4 ? {out_q[3:0], 4'h0} : {out_q[6:0], 1'b0};
        out_cnt_q <= out_cnt_q - 3'd1;
      end
    end
  end

  // pointer moves when a byte is taken; overrun wraps
  always_ff @(posedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      ptr_q <= 24'h000000;
    else if (state_q == ST_ADDR)
      ptr_q <= addr_shift;
    else if (read_phase && byte_done && src_q <= SRC_PAR)
      ptr_q <= ptr_q + 24'h000001;
  end

  // pins: single mode answers on io 1, the line the host listens to
  assign io_o    = drive_q ? (lanes4 ? out_q[7:4]
                                     : {2'b00, out_q[7], 1'b0})
                           : 4'h0;
  assign io_oe_o = !cs_n_i && drive_q ? (lanes4 ? 4'hf : 4'h2) : 4'h0;

  // request events at chip select rise, crossing by toggle
  wire wr_len_ok = (wbits_q == 5'd8) || (wbits_q == 5'd16);
  always_ff @(posedge cs_n_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      req_tog_q  <= 1'b0;
      write_enable_cmd_tog_q <= 1'b0;
      req_data_q <= 16'h0000;
      req_two_q  <= 1'b0;
    end
    else
    begin
      if (wr_cmd_q && wr_len_ok)
      begin
        req_tog_q  <= !req_tog_q;
        req_data_q <= wdata_q;
        req_two_q  <= (wbits_q == 5'd16);
      end
      if (write_enable_cmd_seen_q)
        write_enable_cmd_tog_q <= !write_enable_cmd_tog_q;
    end
  end

  // crossings into the system clock
  fic_sync u_req_sync
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .level_i (req_tog_q),
    .level_o (req_sync)
  );
  fic_sync u_write_enable_cmd_sync
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .level_i (write_enable_cmd_tog_q),
    .level_o (write_enable_cmd_sync)
  );
  fic_sync u_wp_sync
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .level_i (wp_n_i),
    .level_o (wp_sync)
  );

  // system-side decisions
  wire req_evt   = req_sync ^ req_seen_q;
  wire write_enable_cmd_evt  = write_enable_cmd_sync ^ write_enable_cmd_seen_sys_q;
  wire busy      = first_status_volatile_q[fic_pkg::SR1_WIP];
  wire hw_lock   = first_status_volatile_q[fic_pkg::SR1_STATUS_WRITE_DISABLE] && !wp_sync &&
                   !first_config_volatile_q[fic_pkg::CR1_QUAD];
  wire accept    = req_evt && first_status_volatile_q[fic_pkg::SR1_WEL] &&
                   !busy && !hw_lock;
  wire done      = busy && (busy_cnt_q == '0);
  wire [7:0] new_sr = req_two_q ? req_data_q[15:8] : req_data_q[7:0];
  wire [7:0] new_cr = req_data_q[7:0];
  logic [7:0] held_sr_q;
  logic [7:0] held_cr_q;
  logic       held_two_q;

  // register file with self-timed write
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      first_status_volatile_q          <= fic_pkg::SR1_RESET;
      first_status_nonvolatile_q         <= fic_pkg::SR1_RESET;
      first_config_volatile_q          <= fic_pkg::CR1_RESET;
      busy_cnt_q      <= '0;
      req_seen_q      <= 1'b0;
      write_enable_cmd_seen_sys_q <= 1'b0;
      held_sr_q       <= 8'h00;
      held_cr_q       <= 8'h00;
      held_two_q      <= 1'b0;
    end
    else
    begin
      req_seen_q      <= req_sync;
      write_enable_cmd_seen_sys_q <= write_enable_cmd_sync;
      if (write_enable_cmd_evt && !busy)
        first_status_volatile_q[fic_pkg::SR1_WEL] <= 1'b1;
      if (accept)
      begin
        first_status_volatile_q[fic_pkg::SR1_WIP] <= 1'b1;
        busy_cnt_q <= ($bits(busy_cnt_q))'(WRITE_CYCLES);
        held_sr_q  <= new_sr;
        held_cr_q  <= new_cr;
        held_two_q <= req_two_q;
      end
      else if (busy && busy_cnt_q != '0)
        busy_cnt_q <= busy_cnt_q - 1'b1;
      if (done)
      begin
        first_status_volatile_q[fic_pkg::SR1_WIP] <= 1'b0;
        first_status_volatile_q[fic_pkg::SR1_WEL] <= 1'b0;
        if (write_fail_i)
        begin
          first_status_volatile_q[fic_pkg::SR1_EFAIL] <= 1'b1;
          first_status_volatile_q[fic_pkg::SR1_PFAIL] <= 1'b1;
        end
        else
        begin
          first_status_volatile_q[fic_pkg::SR1_STATUS_WRITE_DISABLE] <= held_sr_q[fic_pkg::SR1_STATUS_WRITE_DISABLE];
          if (protect_field_nonvolatile_select_i)
            first_status_volatile_q[fic_pkg::SR1_BP_HI:fic_pkg::SR1_BP_LO] <=
              held_sr_q[fic_pkg::SR1_BP_HI:fic_pkg::SR1_BP_LO];
          else
            first_status_nonvolatile_q[fic_pkg::SR1_BP_HI:fic_pkg::SR1_BP_LO] <=
              held_sr_q[fic_pkg::SR1_BP_HI:fic_pkg::SR1_BP_LO];
          if (held_two_q)
            first_config_volatile_q <= held_cr_q;
        end
      end
    end
  end

  // outward views
  assign first_status_volatile_o    = first_status_volatile_q;
  assign first_status_nonvolatile_o = first_status_nonvolatile_q;
  assign first_config_volatile_o    = first_config_volatile_q;
endmodule
`default_nettype wire

// ==== sim/fic_cmd_chk.sv ====
// checker: timing relations on the command block's system-side and link ports
`timescale 1ns/1ns
`default_nettype none
module fic_cmd_chk
#(
  parameter int WRITE_CYCLES = 200
)
(
  // clock and reset
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  // watched ports
  input wire logic       cs_n_i,
  input wire logic       write_fail_i,
  input wire logic [7:0] second_config_volatile_i,
  input wire logic [3:0] io_oe_o,
  input wire logic [7:0] first_status_volatile_o
);
  logic [15:0] busy_q;
  logic [15:0] busy_d;
  wire logic   write_in_progress_flag = first_status_volatile_o[0];
  wire logic   write_enable_latch = first_status_volatile_o[1];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // length of the current busy period, zero while idle
  assign busy_d = write_in_progress_flag ? busy_q + 16'h1 : 16'h0;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      busy_q <= 16'h0;
    else
      busy_q <= busy_d;
  end
  AST_WIP_LEN: assert property (
    $fell(write_in_progress_flag) |-> busy_q >= WRITE_CYCLES - 1 && busy_q <= WRITE_CYCLES + 1)
    else $error("busy period has the wrong length");
  AST_WEL_CLR: assert property (
    $fell(write_in_progress_flag) |-> !write_enable_latch) else $error("latch not cleared at write end");
  AST_WEL_BUSY: assert property (
    $rose(write_in_progress_flag) |-> write_enable_latch[*4]) else $error("latch dropped while busy");
  AST_WEL_SET: assert property (
    $rose(write_enable_latch) |-> cs_n_i) else $error("latch set inside a frame");
  AST_IDLE_QUIET: assert property (
    cs_n_i[*4] |-> io_oe_o == 4'h0) else $error("pins driven while idle");
  AST_SINGLE_LANE: assert property (
    !second_config_volatile_i[6] |-> io_oe_o[3:2] == 2'b00 && !io_oe_o[0])
    else $error("single mode drives a wrong line");
  AST_QUAD_LANES: assert property (
    second_config_volatile_i[6] && io_oe_o != 4'h0 |-> io_oe_o == 4'hf)
    else $error("quad mode drives a partial lane set");
  AST_FAIL_BOTH: assert property (
    $rose(first_status_volatile_o[6]) |->
      first_status_volatile_o[5] && write_fail_i)
    else $error("fail flags set without a failure");
endmodule
bind fic_cmd fic_cmd_chk #(.WRITE_CYCLES(WRITE_CYCLES)) fic_cmd_chk_inst (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
  .write_fail_i(write_fail_i),
  .second_config_volatile_i(second_config_volatile_i),
  .io_oe_o(io_oe_o), .first_status_volatile_o(first_status_volatile_o));
`default_nettype wire

// ==== sim/fic_host.sv ====
// host controller model: frames commands on the serial link
`timescale 1ns/1ns
`default_nettype none
module fic_host
(
  // link pins
  output logic            sck_o,
  output logic            cs_n_o,
  output logic [3:0]      io_o,
  output logic [3:0]      io_oe_o,
  // resolved data pins
  input  wire logic [3:0] pin_i
);
  // idle: clock low and still, select high
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
    io_oe_o = 4'h0;
  end
  // ntx bits out msb first, then nrx bits in; a frame may stop anywhere
  task automatic frame(input logic [63:0] tx, input int ntx, nrx,
                       input bit q, output logic [63:0] rx);
    int w;
    w = q ? 4 : 1;
    rx = '0;
    #150 cs_n_o = 1'b0; // gap so the system side sees select high
    for (int i = 0; i < ntx; i += w)
    begin
      io_oe_o = q ? 4'hf : 4'h1;
      io_o = q ? tx[63-i -: 4] : {io_o[3:1], tx[63-i]};
      #32 sck_o = 1'b1;
      #32 sck_o = 1'b0;
    end
    io_oe_o = 4'h0;
    for (int i = 0; i < nrx; i += w)
    begin
      #32 rx = q ? {rx[59:0], pin_i} : {rx[62:0], pin_i[1]};
      sck_o = 1'b1;
      #32 sck_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== sim/fic_cmd_bench.sv ====
// self-checking bench for the command block
`timescale 1ns/1ns
`default_nettype none
module fic_cmd_bench;
  localparam int WCYC = 100;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wp_n_q = 1'b1;
  logic [7:0]  cfg2_q = 8'h00;
  logic        sel_q = 1'b1;
  logic        fail_q = 1'b0;
  logic        twe_q = 1'b0;
  logic        tsel_q = 1'b0;
  logic [7:0]  taddr_q = 8'h00;
  logic [7:0]  tdata_q = 8'h00;
  logic        sck, cs_n, drove;
  logic [3:0]  h_o, h_oe, d_o, d_oe;
  logic [7:0]  first_status_volatile, first_status_nonvolatile, first_config_volatile;
  logic [63:0] rx;
  int          mismatches = 0;
  int          total_checks = 0;
  // released lines show the inverse of their last value
  wire logic [3:0] pin = (d_oe & d_o) | (~d_oe & h_oe & h_o)
                       | (~d_oe & ~h_oe & ~h_o);
  fic_cmd #(.WRITE_CYCLES(WCYC)) fic_cmd_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n),
    .io_i(pin), .io_o(d_o), .io_oe_o(d_oe), .wp_n_i(wp_n_q),
    .second_config_volatile_i(cfg2_q),
    .protect_field_nonvolatile_select_i(sel_q), .status_two_i(8'ha5),
    .write_fail_i(fail_q), .first_status_volatile_o(first_status_volatile),
    .first_status_nonvolatile_o(first_status_nonvolatile), .first_config_volatile_o(first_config_volatile),
    .table_we_i(twe_q), .table_sel_i(tsel_q), .table_addr_i(taddr_q),
    .table_data_i(tdata_q));
  fic_host fic_host_inst (.sck_o(sck), .cs_n_o(cs_n), .io_o(h_o),
    .io_oe_o(h_oe), .pin_i(pin));
  // system clock and a flag for any device drive
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) if (d_oe != 4'h0) drove = 1'b1;
  function automatic logic [7:0] pat(input logic s, input int a);
    return {s, a[6:0]} ^ 8'h5a;
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for the self-timed write; a timeout ends the run as failed
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (6) @(posedge clock_i);
    while (first_status_volatile[0] !== 1'b0 && n < 400)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n == 400)
    begin
      mismatches++;
      end_sim;
    end
  endtask
  task automatic rd(input logic [63:0] tx, input int ntx, nby, input bit q);
    drove = 1'b0;
    fic_host_inst.frame(tx, ntx, nby * 8, q, rx);
  endtask
  task automatic tab(input int nby, input logic s, input int base);
    for (int k = 0; k < nby; k++)
      chk8(rx[8*(nby-1-k) +: 8], pat(s, base + k));
  endtask
  task automatic wr(input logic [7:0] st, cf, input int nb, input bit q, en);
    if (en)
      fic_host_inst.frame({fic_pkg::OP_WRITE_ENABLE_CMD, 56'h0}, 8, 0, q, rx);
    fic_host_inst.frame({fic_pkg::OP_REG_WRITE, st, cf, 40'h0}, 8 + nb, 0,
                        q, rx);
    if (fail_q)
      repeat (WCYC + 20) @(posedge clock_i);
    else
      wait_idle;
  endtask
  task automatic s_load;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clock_i);
      twe_q <= 1'b1;
      tsel_q <= i[4];
      taddr_q <= {4'h0, i[3:0]};
      tdata_q <= pat(i[4], i[3:0]);
    end
    @(posedge clock_i);
    twe_q <= 1'b0;
  endtask
  task automatic s_busy;
    wr(8'h1c, 8'h00, 8, 1'b0, 1'b1);
    chk8(first_status_volatile, 8'h1c);
    fic_host_inst.frame({fic_pkg::OP_WRITE_ENABLE_CMD, 56'h0}, 8, 0, 1'b0, rx);
    fic_host_inst.frame({fic_pkg::OP_REG_WRITE, 8'h14, 48'h0}, 16, 0, 1'b0,
                        rx);
    rd({fic_pkg::OP_STAT1, 56'h0}, 8, 3, 1'b0);
    chk8(rx[23:16], 8'h1f);
    chk8(rx[7:0], 8'h14);
    wait_idle;
    wr(8'h00, 8'h00, 8, 1'b0, 1'b0);
    chk8(first_status_volatile, 8'h14);
    wr(8'h00, 8'h00, 12, 1'b0, 1'b1);
    chk8(first_status_volatile & 8'hfc, 8'h14);
    @(posedge clock_i) sel_q <= 1'b0;
    wr(8'h08, 8'h00, 8, 1'b0, 1'b1);
    chk8(first_status_nonvolatile & 8'h1c, 8'h08);
    @(posedge clock_i) sel_q <= 1'b1;
  endtask
  task automatic s_protect;
    @(posedge clock_i) wp_n_q <= 1'b0;
    wr(8'h80, 8'h02, 16, 1'b0, 1'b1);
    chk8(first_config_volatile, 8'h02);
    rd({fic_pkg::OP_CFG, 56'h0}, 8, 2, 1'b0);
    chk8(rx[15:8] & rx[7:0], 8'h02);
    wr(8'h84, 8'h00, 16, 1'b0, 1'b1);
    chk8(first_status_volatile, 8'h84);
    wr(8'h00, 8'h00, 8, 1'b0, 1'b1);
    chk8(first_status_volatile & 8'hfc, 8'h84);
    @(posedge clock_i) wp_n_q <= 1'b1;
    wr(8'h00, 8'h00, 8, 1'b0, 1'b1);
    chk8(first_status_volatile, 8'h00);
  endtask
  task automatic s_reads;
    rd({fic_pkg::OP_STAT2, 56'h0}, 8, 2, 1'b0);
    chk8(rx[15:8] | rx[7:0], 8'ha5);
    rd({fic_pkg::OP_ID, 56'h0}, 8, 6, 1'b0);
    tab(6, 1'b0, 0);
    rd({fic_pkg::OP_PARAM, 56'h0}, 40, 2, 1'b0);
    tab(2, 1'b1, 0);
    rd({fic_pkg::OP_PARAM, 24'h000009, 32'h0}, 40, 3, 1'b0);
    tab(3, 1'b1, 9);
    rd({fic_pkg::OP_QUAD_ID, 56'h0}, 8, 1, 1'b0);
    chk8({7'h0, drove}, 8'h00);
  endtask
  task automatic s_quad;
    @(posedge clock_i) cfg2_q <= 8'h40;
    rd({fic_pkg::OP_QUAD_ID, 56'h0}, 8, 5, 1'b1);
    tab(5, 1'b0, 0);
    rd({fic_pkg::OP_PARAM, 24'h000005, 32'h0}, 64, 2, 1'b1);
    tab(2, 1'b1, 5);
    wr(8'h1c, 8'h00, 16, 1'b1, 1'b1);
    rd({fic_pkg::OP_STAT1, 56'h0}, 8, 1, 1'b1);
    chk8(rx[7:0], 8'h1c);
    rd({fic_pkg::OP_STAT2, 56'h0}, 8, 1, 1'b1);
    chk8({7'h0, drove}, 8'h00);
    @(posedge clock_i) cfg2_q <= 8'h00;
  endtask
  task automatic s_fail;
    @(posedge clock_i) fail_q <= 1'b1;
    wr(8'h00, 8'h00, 8, 1'b0, 1'b1);
    chk8(first_status_volatile & 8'h60, 8'h60);
    @(posedge clock_i) fail_q <= 1'b0;
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    chk8(first_status_volatile, fic_pkg::SR1_RESET);
    chk8(first_config_volatile, fic_pkg::CR1_RESET);
  endtask
  // main sequence after twelve cycles of reset
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    s_load;
    chk8(first_status_volatile, fic_pkg::SR1_RESET);
    s_busy;
    s_protect;
    s_reads;
    s_quad;
    s_fail;
    end_sim;
  end
endmodule
`default_nettype wire
